// ==== verilog/nvmpc_pkg.sv ====
// package of constants for the nonvolatile program/verify and configuration block
package nvmpc_pkg;
  // configuration byte 0 field positions
  localparam int CFG_WAIT_HI_BIT = 6;
  localparam int CFG_WAIT_LO_BIT = 5;
  localparam int CFG_LATCH_EXT_BIT = 4;
  localparam int CFG_PAGE_BIT = 1;
  // configuration fetch addresses at the top of code space
  localparam logic [15:0] CFG0_ADDR = 16'hFFF8;
  localparam logic [15:0] CFG1_ADDR = 16'hFFF9;
  localparam logic [7:0] CFG_RESET = 8'hFF;
  // mode codes on port 0
  localparam logic [7:0] MODE_PROGRAM_STROBE_N_CODE = 8'h68;
  localparam logic [7:0] MODE_VER_CODE = 8'h28;
  localparam logic [7:0] MODE_VER_SIG = 8'h29;
  localparam logic [7:0] MODE_VER_LOCK = 8'h2B;
  // signature addresses
  localparam logic [15:0] SIG_MAKER_ADDR = 16'h0030;
  localparam logic [15:0] SIG_CORE_ADDR = 16'h0031;
  localparam logic [15:0] SIG_DEV_ADDR = 16'h0060;
  localparam logic [15:0] LOCK_ADDR = 16'h0000;
  localparam int LOCK_LSB = 1;
  // timing: oscillator periods for read data and float and for the latch strobe, and the clock period in ns
  localparam int ACCESS_TOSC = 48;
  localparam int LATCH_EXT_TOSC = 3;
  localparam int CLK_NS = 20;
  // code array geometry
  localparam int CODE_AW = 14;
  localparam int CODE_WORDS = 16384;
  localparam int READ_LAT = 4;
  typedef enum logic [1:0] {NVMPC_IDLE, NVMPC_CFG0, NVMPC_CFG1, NVMPC_RUN} nvmpc_boot_t;
endpackage

// ==== verilog/nvmpc_mem.sv ====
// code memory array with registered read data
module nvmpc_mem
(
  input wire logic clk_i, // system clock
  input wire logic we_i, // write strobe
  input wire logic [nvmpc_pkg::CODE_AW-1:0] addr_i, // word address
  input wire logic [7:0] wdata_i, // write data
  output logic [7:0] rdata_o // registered read data
);
  logic [7:0] mem_q [nvmpc_pkg::CODE_WORDS];

  // single port, read data always from a register
  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem_q[addr_i] <= wdata_i;
    end
    rdata_o <= mem_q[addr_i];
  end
endmodule // nvmpc_mem

// ==== verilog/nvmpc_top.sv ====
// configuration decode and parallel program/verify port
// Behaviour
// - config bits 6:5 give code wait states: 11=0, 10=1, 01=2, 00=3
// - config bit 4 set: latch strobe one period; clear: three periods
// - config bit 1 clear selects page mode, set selects nonpage mode
// - romless part fetches configuration bytes from external FFF8/FFF9 after reset
// - verify data valid within 48 periods of address valid
// - verify data valid within 48 periods of enable low
// - data port floats within 48 periods after enable released
// - signature bytes at 30H, 31H, 60H: maker, core, device
// - mode code 68H programs code, 28H verifies code, 29H verifies signature
// - address high byte on port 1, low byte on port 3, area relative
// - verify-lock returns three lock bits on port 2 bits 3..1, high programmed
module nvmpc_top
#(
  parameter logic [7:0] SIG_MAKER = 8'h11, // arbitrary value
  parameter logic [7:0] SIG_CORE = 8'h22, // arbitrary value
  parameter logic [7:0] SIG_DEVICE = 8'h33, // arbitrary value
  parameter bit HAS_ROM = 1'b0 // no internal array: configuration comes from outside
)
(
  input wire logic clk_i, // 50 MHz clock
  input wire logic nrst_i, // async reset, active low
  input wire logic program_strobe_n_i, // programming strobe pin, active low
  input wire logic enable_i, // verify output enable pin, high disables output
  input wire logic [7:0] p0_mode_i, // mode code on port 0
  input wire logic [7:0] p1_addr_hi_i, // address high on port 1
  input wire logic [7:0] p3_addr_lo_i, // address low on port 3
  input wire logic [7:0] p2_i, // port 2 input (program data)
  input wire logic [2:0] lock_bits_i, // stored lock bit states
  input wire logic [7:0] ext_cfg_data_i, // external memory data for config fetch
  input wire logic [7:0] rom_cfg0_i, // factory configuration byte when internal array exists
  output logic [7:0] p2_o, // port 2 output (verify data)
  output logic p2_oe_o, // port 2 driven
  output logic [15:0] cfg_fetch_addr_o, // address for configuration fetch
  output logic cfg_fetch_o, // configuration fetch in progress
  output logic cfg_valid_o, // configuration loaded
  output logic [1:0] code_wait_states_o, // external code wait states
  output logic [1:0] latch_strobe_tosc_o, // latch strobe length in periods
  output logic page_mode_o, // page mode bus multiplexing
  output logic [7:0] user_config_byte0_o // configuration byte 0 readback
);
  logic [1:0] rst_sync_q;
  logic rst_n;
  // release reset through two flops
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // pin synchronisers, first stage read only by second
  // one bundle, so strobe, mode, address and data all see the same two-flop delay
  logic [36:0] pin_s1_q, pin_s2_q;
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_q <= 37'h1FFFFFFFFF;
      pin_s2_q <= 37'h1FFFFFFFFF;
    end
    else
    begin
      pin_s1_q <= {program_strobe_n_i, enable_i, p0_mode_i, p1_addr_hi_i, p3_addr_lo_i, p2_i, lock_bits_i};
      pin_s2_q <= pin_s1_q;
    end
  end
  wire program_strobe_n_n = pin_s2_q[36];
  wire en_hi = pin_s2_q[35];
  wire [7:0] mode = pin_s2_q[34:27];
  wire [15:0] addr = pin_s2_q[26:11];
  wire [7:0] pdata = pin_s2_q[10:3];
  wire [2:0] lock = pin_s2_q[2:0];

  // decode helpers, one for the wait states output and one for the latch strobe output
  function automatic logic [1:0] wait_decode(input logic [7:0] c);
    wait_decode = ~c[nvmpc_pkg::CFG_WAIT_HI_BIT:nvmpc_pkg::CFG_WAIT_LO_BIT];
  endfunction
  function automatic logic [1:0] latch_decode(input logic [7:0] c);
    latch_decode = c[nvmpc_pkg::CFG_LATCH_EXT_BIT] ? 2'h1 : 2'(nvmpc_pkg::LATCH_EXT_TOSC);
  endfunction

  // configuration fetch after reset
  nvmpc_pkg::nvmpc_boot_t boot_q;
  logic [7:0] cfg0_q;
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      boot_q <= nvmpc_pkg::NVMPC_IDLE;
      cfg0_q <= nvmpc_pkg::CFG_RESET;
    end
    else
    begin
      case (boot_q)
        nvmpc_pkg::NVMPC_IDLE: boot_q <= HAS_ROM ? nvmpc_pkg::NVMPC_RUN : nvmpc_pkg::NVMPC_CFG0;
        nvmpc_pkg::NVMPC_CFG0: boot_q <= nvmpc_pkg::NVMPC_CFG1;
        nvmpc_pkg::NVMPC_CFG1:
        begin
          cfg0_q <= ext_cfg_data_i;
          boot_q <= nvmpc_pkg::NVMPC_RUN;
        end
        nvmpc_pkg::NVMPC_RUN: boot_q <= nvmpc_pkg::NVMPC_RUN;
        default: boot_q <= nvmpc_pkg::NVMPC_IDLE;
      endcase
      if (HAS_ROM && boot_q == nvmpc_pkg::NVMPC_IDLE)
        cfg0_q <= rom_cfg0_i;
    end
  end
  // fetch and byte 0 address go out together from idle; the external memory answers
  // one cycle later, so the byte stands on the bus when the CFG1 state latches it
  wire fetching = !HAS_ROM && ((boot_q == nvmpc_pkg::NVMPC_IDLE) || (boot_q == nvmpc_pkg::NVMPC_CFG0));

  // decoded settings, bit 7 is not decoded and only reaches the byte 0 readback
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      code_wait_states_o <= 2'h3;
      latch_strobe_tosc_o <= 2'h3;
      page_mode_o <= 1'b0;
      user_config_byte0_o <= nvmpc_pkg::CFG_RESET;
      cfg_valid_o <= 1'b0;
      cfg_fetch_o <= 1'b0;
      cfg_fetch_addr_o <= 16'h0000;
    end
    else
    begin
      code_wait_states_o <= wait_decode(cfg0_q);
      latch_strobe_tosc_o <= latch_decode(cfg0_q);
      page_mode_o <= ~cfg0_q[nvmpc_pkg::CFG_PAGE_BIT];
      user_config_byte0_o <= cfg0_q;
      cfg_valid_o <= (boot_q == nvmpc_pkg::NVMPC_RUN);
      cfg_fetch_o <= fetching;
      cfg_fetch_addr_o <= (boot_q == nvmpc_pkg::NVMPC_IDLE) ? nvmpc_pkg::CFG0_ADDR : nvmpc_pkg::CFG1_ADDR;
    end
  end

  // program strobe falling edge writes code memory in program mode
  logic program_strobe_n_n_q;
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      program_strobe_n_n_q <= 1'b1;
    else
      program_strobe_n_n_q <= program_strobe_n_n;
  end
  // address and data are held steady by the programmer around the pulse, so the edge is safe
  wire program_strobe_n_fall = program_strobe_n_n_q && !program_strobe_n_n;
  wire mode_program_strobe_n = (mode == nvmpc_pkg::MODE_PROGRAM_STROBE_N_CODE);
  wire mem_we = program_strobe_n_fall && mode_program_strobe_n && (addr < 16'(nvmpc_pkg::CODE_WORDS));
  logic [7:0] mem_rdata;

  nvmpc_mem u_mem
  (
    .clk_i(clk_i),
    .we_i(mem_we),
    .addr_i(addr[nvmpc_pkg::CODE_AW-1:0]),
    .wdata_i(pdata),
    .rdata_o(mem_rdata)
  );

  // verify data select
  wire [7:0] sig_byte = (addr == nvmpc_pkg::SIG_MAKER_ADDR) ? SIG_MAKER :
                        (addr == nvmpc_pkg::SIG_CORE_ADDR) ? SIG_CORE :
                        (addr == nvmpc_pkg::SIG_DEV_ADDR) ? SIG_DEVICE : 8'h00;
  wire [7:0] lock_byte = {4'h0, lock, 1'b0};
  wire [7:0] code_byte = (addr < 16'(nvmpc_pkg::CODE_WORDS)) ? mem_rdata : 8'hFF;
  wire [7:0] ver_data = (mode == nvmpc_pkg::MODE_VER_SIG) ? sig_byte :
                        (mode == nvmpc_pkg::MODE_VER_LOCK && addr == nvmpc_pkg::LOCK_ADDR) ? lock_byte :
                        code_byte;
  wire ver_mode = (mode == nvmpc_pkg::MODE_VER_CODE) || (mode == nvmpc_pkg::MODE_VER_SIG) ||
                  (mode == nvmpc_pkg::MODE_VER_LOCK);
  // drive only while enabled low and verifying with strobe high
  wire drive = ver_mode && !en_hi && program_strobe_n_n;

  // output register: data valid a few cycles after pin change, far inside 48 periods
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      p2_o <= 8'h00;
      p2_oe_o <= 1'b0;
    end
    else
    begin
      p2_o <= ver_data;
      p2_oe_o <= drive;
    end
  end

  // the 48 periods are of a 4-6 MHz oscillator; our fixed latency stays far below that
  a_float_after_en: assert property (@(posedge clk_i) disable iff (!rst_n)
    $rose(en_hi) |-> ##1 !p2_oe_o) else $error("port 2 still driven after enable");
  a_drive_on_en: assert property (@(posedge clk_i) disable iff (!rst_n)
    ($fell(en_hi) && ver_mode && program_strobe_n_n) |-> ##[1:3] p2_oe_o) else $error("no drive after enable");
  a_sig_maker: assert property (@(posedge clk_i) disable iff (!rst_n)
    (mode == nvmpc_pkg::MODE_VER_SIG && addr == nvmpc_pkg::SIG_MAKER_ADDR) |=> p2_o == SIG_MAKER)
    else $error("maker signature wrong");
  a_lock_bits: assert property (@(posedge clk_i) disable iff (!rst_n)
    (mode == nvmpc_pkg::MODE_VER_LOCK && addr == nvmpc_pkg::LOCK_ADDR) |=> p2_o[3:1] == $past(lock))
    else $error("lock bits wrong");
  a_wait_decode: assert property (@(posedge clk_i) disable iff (!rst_n)
    cfg_valid_o |-> code_wait_states_o == ~user_config_byte0_o[6:5]) else $error("wait decode wrong");
  a_latch_len: assert property (@(posedge clk_i) disable iff (!rst_n)
    cfg_valid_o |-> latch_strobe_tosc_o == (user_config_byte0_o[4] ? 2'h1 : 2'h3)) else $error("latch len");
  a_page_sel: assert property (@(posedge clk_i) disable iff (!rst_n)
    cfg_valid_o |-> page_mode_o == !user_config_byte0_o[1]) else $error("page mode wrong");
  a_cfg_boot: assert property (@(posedge clk_i) disable iff (!rst_n)
    $rose(rst_n) |-> ##[1:6] cfg_valid_o) else $error("configuration not loaded");
  a_no_write: assert property (@(posedge clk_i) disable iff (!rst_n)
    !mode_program_strobe_n |-> !mem_we) else $error("write outside program mode");
  a_program_strobe_n_no_drive: assert property (@(posedge clk_i) disable iff (!rst_n)
    mode_program_strobe_n |=> !p2_oe_o) else $error("port 2 driven in program mode");
endmodule // nvmpc_top

// ==== verif/nvmpc_ext_mem.sv ====
// external application memory model answering the configuration fetch
module nvmpc_ext_mem
(
  input wire logic clk_i, // system clock
  input wire logic fetch_i, // fetch in progress
  input wire logic [15:0] addr_i, // fetch address
  input wire logic [7:0] cfg0_i, // byte held at the byte 0 location
  output logic [7:0] data_o // data bus back to the device
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] bus_q = 8'h3C;
  assign data_o = bus_q;
  // one cycle access; an idle bus toggles so stale data never passes for a byte
  always @(posedge clk_i)
  begin
    if (fetch_i && addr_i === nvmpc_pkg::CFG0_ADDR)
      bus_q <= cfg0_i;
    else if (fetch_i && addr_i === nvmpc_pkg::CFG1_ADDR)
      bus_q <= 8'hFF;
    else
      bus_q <= ~bus_q;
  end
endmodule // nvmpc_ext_mem

// ==== verif/tb.sv ====
// self-checking bench for the configuration decode and program/verify port
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] SIG_A = 8'h5A; // arbitrary value
  localparam logic [7:0] SIG_B = 8'h6B; // arbitrary value
  localparam logic [7:0] SIG_C = 8'h7C; // arbitrary value
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic strobe_n = 1'b1;
  logic enable = 1'b1;
  logic [7:0] mode = 8'h00, ahi = 8'h00, alo = 8'h00, pdata = 8'h00, cfg = 8'hFF;
  logic [2:0] lock = 3'h0;
  wire [7:0] ext_data, p2_o, cfg_b;
  wire p2_oe, fetch, cfg_valid, page;
  wire [15:0] fetch_addr;
  wire [1:0] waits, latch;
  wire [7:0] p2_wire = p2_oe ? p2_o : pdata; // shared port 2 level
  int error_cnt = 0, num_checks = 0, cycles = 0;
  int mem[int];
  nvmpc_top #(.SIG_MAKER(SIG_A), .SIG_CORE(SIG_B), .SIG_DEVICE(SIG_C)) i_nvmpc_top (.clk_i(clk_i),
    .nrst_i(nrst_i), .program_strobe_n_i(strobe_n), .enable_i(enable), .p0_mode_i(mode),
    .p1_addr_hi_i(ahi), .p3_addr_lo_i(alo), .p2_i(p2_wire), .lock_bits_i(lock), .ext_cfg_data_i(ext_data),
    .rom_cfg0_i(8'hFF), .p2_o(p2_o), .p2_oe_o(p2_oe), .cfg_fetch_addr_o(fetch_addr), .cfg_fetch_o(fetch),
    .cfg_valid_o(cfg_valid), .code_wait_states_o(waits), .latch_strobe_tosc_o(latch), .page_mode_o(page),
    .user_config_byte0_o(cfg_b));
  nvmpc_ext_mem i_nvmpc_ext_mem (.clk_i(clk_i), .fetch_i(fetch), .addr_i(fetch_addr), .cfg0_i(cfg),
    .data_o(ext_data));
  // free-running clock and a hang limit well above the planned run
  initial forever #10 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask
  // reset with a chosen byte in external memory, then check the decode
  task automatic do_reset(input logic [7:0] c);
    nrst_i = 1'b0;
    cfg = c;
    cyc(16);
    nrst_i = 1'b1;
    cyc(12);
    chk("cfg_valid", 16'h1, {15'h0, cfg_valid});
    chk("config byte", {8'h0, c}, {8'h0, cfg_b});
    chk("wait states", {14'h0, ~c[6:5]}, {14'h0, waits});
    chk("latch length", c[4] ? 16'h1 : 16'h3, {14'h0, latch});
    chk("page mode", {15'h0, ~c[1]}, {15'h0, page});
  endtask
  // address and enable move together, so one bound covers both delays
  task automatic verify(input logic [7:0] m, input logic [15:0] a, output logic [7:0] d);
    mode = m;
    ahi = a[15:8];
    alo = a[7:0];
    enable = 1'b0;
    cyc(48);
    chk("drive enable", 16'h1, {15'h0, p2_oe});
    d = p2_wire;
    enable = 1'b1;
    cyc(48);
    chk("float", 16'h0, {15'h0, p2_oe});
  endtask
  task automatic program_strobe_n(input logic [7:0] m, input logic [15:0] a, input logic [7:0] d);
    mode = m;
    ahi = a[15:8];
    alo = a[7:0];
    pdata = d;
    cyc(48);
    strobe_n = 1'b0;
    cyc(4500);
    strobe_n = 1'b1;
    cyc(500);
    if (m == nvmpc_pkg::MODE_PROGRAM_STROBE_N_CODE && a < 16'h4000)
      mem[a] = d;
  endtask
  initial
  begin
    logic [7:0] d;
    logic [15:0] a;
    logic [15:0] sa[3];
    logic [7:0] sv[3];
    sa = '{nvmpc_pkg::SIG_MAKER_ADDR, nvmpc_pkg::SIG_CORE_ADDR, nvmpc_pkg::SIG_DEV_ADDR};
    sv = '{SIG_A, SIG_B, SIG_C};
    d = 8'($urandom(32'h382F57D8));
    for (int i = 0; i < 4; i++)
    begin
      d = 8'($urandom);
      d[6:5] = 2'(i);
      d[4] = d[6] ^ d[5];
      d[1] = d[5];
      do_reset(d);
    end
    // each address is written, then hit by a refused write in verify mode
    for (int i = 0; i < 3; i++)
    begin
      a = 16'($urandom) & 16'h3FFF;
      d = 8'($urandom);
      program_strobe_n(nvmpc_pkg::MODE_PROGRAM_STROBE_N_CODE, a, d);
      program_strobe_n(nvmpc_pkg::MODE_VER_CODE, a, ~d);
    end
    foreach (mem[k])
    begin
      verify(nvmpc_pkg::MODE_VER_CODE, 16'(k), d);
      chk("code byte", 16'(mem[k]), {8'h0, d});
    end
    verify(nvmpc_pkg::MODE_VER_CODE, 16'h4000, d);
    chk("out of range byte", 16'h00FF, {8'h0, d});
    for (int i = 0; i < 3; i++)
    begin
      verify(nvmpc_pkg::MODE_VER_SIG, sa[i], d);
      chk("signature", {8'h0, sv[i]}, {8'h0, d});
    end
    lock = 3'($urandom);
    verify(nvmpc_pkg::MODE_VER_LOCK, nvmpc_pkg::LOCK_ADDR, d);
    chk("lock bits", {13'h0, lock}, {13'h0, d[3:1]});
    finish_test();
  end
endmodule // tb
